// ---- verilog/fetch_pc_pipeline.sv ----
// program counter and fetch pipeline with an AHB-Lite register port
// Notes on behaviour
// [RQ1] four phases make one instruction cycle
// [RQ2] counter advances and fetches in first phase
// [RQ3] decode and execute in phases two-four
// [RQ4] fetch overlaps execute; extended takes two
// [RQ5] branches cost one extra cycle; here a taken branch leaves two dead slots
// [RQ6] counter increments after each sequential instruction
// [RQ7] jump, call, interrupt, reset load counter
// [RQ8] taken skip discards prefetch, runs dummy
// [RQ9] counter is thirteen bits, five plus eight
// [RQ10] low byte readable and writable by software
// [RQ11] low byte write jumps within page
// [RQ12] low byte write inserts dummy cycle
// [RQ13] eight-bit ALU through accumulator
// [RQ14] reset restarts fetching at address zero
// [RQ15] low byte write keeps upper bits
//
// Implementation choices: the AHB-Lite register port and the address map.
`include "fetch_cfg.svh"
`default_nettype none
module fetch_pc_pipeline
  import fetch_pkg::*;
#(
  parameter int PC_W = `PC_WIDTH
)(
  input  wire logic        hclk,       // system clock
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write
  input  wire logic [2:0]  hsize,      // size, word only
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready in
  output logic [31:0]      hrdata,     // read data
  output logic             hreadyout,  // slave ready
  output logic             hresp,      // always okay
  output logic [PC_W-1:0]  pmem_addr,  // program memory address
  output logic             pmem_rd,    // fetch strobe in first phase
  input  wire logic [15:0] pmem_data,  // instruction word
  output logic [15:0]      instr,      // instruction in execution
  output logic             exec_valid, // instr is live, not dummy
  output logic [3:0]       instruction_phase_clocks, // phase outputs
  output logic [7:0]       acc         // accumulator
);
  import fetch_pkg::*;

  phase_t     phase;
  logic [3:0] ph_oh;
  logic       run;
  logic [PC_W-1:0] pc;
  logic [15:0] prefetch;
  seq_t       seq;
  logic       ext_half;
  logic       pend_cmd;
  op_kind_t   cmd_kind;
  logic [PC_W-1:0] cmd_target;
  logic       pend_pcl;
  logic [7:0] pcl_val;
  logic [7:0] alu_b;
  logic [2:0] alu_op;
  logic       pend_alu;
  logic [7:0] next_acc;
  logic       a_valid;
  logic       a_write;
  logic [7:0] a_addr;
  logic       wr_pcl;
  logic       wr_cmd;
  logic       wr_ctrl;
  logic       wr_alu;
  logic       cycle_end;
  logic [4:0] pc_upper_bits;
  logic [7:0] pc_lower_bits;

  localparam logic [7:0] ALU_OFFSET = 8'h18;

  // [RQ1] phase sequencer
  phase_gen u_phase (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .run                      (run),
    .phase                    (phase),
    .instruction_phase_clocks (ph_oh)
  );

  assign cycle_end     = run && (phase == ph_t4);
  // [RQ9] split view of the counter
  assign pc_upper_bits = pc[12:8];
  assign pc_lower_bits = pc[7:0];

  // bus address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_addr  <= 8'h00;
    end
    else if (hready)
    begin
      a_valid <= hsel && htrans[1];
      a_write <= hwrite;
      a_addr  <= haddr[7:0];
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end

  always_comb
  begin
    wr_pcl  = 1'b0;
    wr_cmd  = 1'b0;
    wr_ctrl = 1'b0;
    wr_alu  = 1'b0;
    if (a_valid && a_write)
    begin
      if (a_addr == `PCL_OFFSET)
        wr_pcl = 1'b1;
      else if (a_addr == `CMD_OFFSET)
        wr_cmd = 1'b1;
      else if (a_addr == `CTRL_OFFSET)
        wr_ctrl = 1'b1;
      else if (a_addr == ALU_OFFSET)
        wr_alu = 1'b1;
    end
  end

  // read data registered at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      // [RQ10] low byte read back
      if (haddr[7:0] == `PCL_OFFSET)
        hrdata <= {24'h00_0000, pc_lower_bits};
      else if (haddr[7:0] == `CTRL_OFFSET)
        hrdata <= {31'h0000_0000, run};
      else if (haddr[7:0] == `STAT_OFFSET)
        hrdata <= {30'h0000_0000, seq == sq_dummy,
                   pend_cmd | pend_pcl};
      else if (haddr[7:0] == `PC_OFFSET)
        hrdata <= {19'h0_0000, pc};
      else if (haddr[7:0] == `IR_OFFSET)
        hrdata <= {16'h0000, instr};
      else if (haddr[7:0] == ALU_OFFSET)
        hrdata <= {24'h00_0000, acc};
      else
        hrdata <= 32'h0000_0000;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      run <= 1'b0;
    else if (wr_ctrl)
      run <= hwdata[`CTRL_RUN_BIT];

  // decoder request, held until taken at an instruction-cycle end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pend_cmd   <= 1'b0;
      cmd_kind   <= op_seq;
      cmd_target <= `RESET_VECTOR;
    end
    else if (wr_cmd)
    begin
      pend_cmd   <= 1'b1;
      cmd_kind   <= op_kind_t'(hwdata[`CMD_KIND_LSB +: 3]);
      cmd_target <= hwdata[`CMD_TARGET_LSB +: PC_W];
    end
    else if (cycle_end && seq == sq_normal && !ext_half)
      pend_cmd <= 1'b0;

  // [RQ10] software write to low byte, set wins over take
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pend_pcl <= 1'b0;
      pcl_val  <= 8'h00;
    end
    else if (wr_pcl)
    begin
      pend_pcl <= 1'b1;
      pcl_val  <= hwdata[7:0];
    end
    else if (cycle_end && seq == sq_normal && !pend_cmd)
      pend_pcl <= 1'b0;

  // [RQ2] fetch strobe and address in the first phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pmem_rd   <= 1'b0;
      pmem_addr <= `RESET_VECTOR;
    end
    else
    begin
      pmem_rd   <= run && (phase == ph_t4);
      // address moves only as a new first phase begins
      if (cycle_end)
        pmem_addr <= pc;
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      prefetch <= 16'h0000;
    else if (pmem_rd)
      prefetch <= pmem_data;

  // [RQ14] counter starts at the reset vector
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pc       <= `RESET_VECTOR;
      seq      <= sq_normal;
      ext_half <= 1'b0;
    end
    else if (cycle_end)
    begin
      case (seq)
        sq_normal:
          // [RQ4] extended instruction holds a second cycle
          if (pend_cmd && cmd_kind == op_extended && !ext_half)
            ext_half <= 1'b1;
          else if (pend_cmd && cmd_kind != op_seq
                   && cmd_kind != op_extended)
          begin
            ext_half <= 1'b0;
            if (cmd_kind == op_skip)
            begin
              // [RQ8] skip: prefetched word dies in this slot
              pc  <= pc + 13'h0001;
            end
            else
            begin
              // [RQ7] load target; [RQ5] extra cycle
              pc  <= cmd_target;
              seq <= sq_branch;
            end
          end
          else if (pend_pcl)
          begin
            // [RQ11] [RQ15] page-local jump keeps upper bits
            pc  <= {pc_upper_bits, pcl_val};
            // [RQ12] dummy while new address prefetches
            seq <= sq_dummy;
          end
          else
          begin
            ext_half <= 1'b0;
            // [RQ6] sequential step
            pc <= pc + 13'h0001;
          end
        sq_branch:
        begin
          // target fetch goes out now, so its slot stays live
          pc  <= pc + 13'h0001;
          seq <= sq_normal;
        end
        default:
        begin
          pc  <= pc + 13'h0001;
          seq <= sq_normal;
        end
      endcase
    end

  // [RQ3] execute register loads at end of phase four
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      instr      <= 16'h0000;
      exec_valid <= 1'b0;
    end
    else if (cycle_end)
    begin
      instr      <= prefetch;
      exec_valid <= (seq == sq_normal) && !pend_pcl
                    && !(pend_cmd && cmd_kind != op_seq
                         && cmd_kind != op_extended);
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      instruction_phase_clocks <= 4'h0;
    else
      instruction_phase_clocks <= run ? {ph_oh[2:0], ph_oh[3]} : 4'h0;

  // operand write: bits 7:0 value, bits 10:8 operation
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pend_alu <= 1'b0;
      alu_b    <= 8'h00;
      alu_op   <= 3'h0;
    end
    else if (wr_alu)
    begin
      pend_alu <= 1'b1;
      alu_b    <= hwdata[7:0];
      alu_op   <= hwdata[10:8];
    end
    else if (run && phase == ph_t3)
      pend_alu <= 1'b0;

  // [RQ13] eight-bit ALU, result back to accumulator
  always_comb
  begin
    case (alu_op)
      3'h0:    next_acc = alu_b;
      3'h1:    next_acc = acc + alu_b;
      3'h2:    next_acc = acc - alu_b;
      3'h3:    next_acc = acc & alu_b;
      3'h4:    next_acc = acc | alu_b;
      3'h5:    next_acc = acc ^ alu_b;
      3'h6:    next_acc = {acc[6:0], acc[7]};
      default: next_acc = acc + 8'h01;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      acc <= 8'h00;
    else if (pend_alu && run && phase == ph_t3)
      acc <= next_acc;

endmodule : fetch_pc_pipeline
`default_nettype wire

// ---- verilog/fetch_cfg.svh ----
// offsets, reset values and timing counts of the fetch front end
`ifndef FETCH_CFG_SVH
`define FETCH_CFG_SVH
`define PCL_OFFSET        8'h00
`define CTRL_OFFSET       8'h04
`define STAT_OFFSET       8'h08
`define PC_OFFSET         8'h0C
`define IR_OFFSET         8'h10
`define CMD_OFFSET        8'h14
`define RESET_VECTOR      13'h0000
`define PC_WIDTH          13
`define PHASE_COUNT       4
`define CTRL_RUN_BIT      0
`define STAT_BUSY_BIT     0
`define STAT_DUMMY_BIT    1
`define CMD_KIND_LSB      16
`define CMD_TARGET_LSB    0
`endif

// ---- verilog/fetch_pkg.sv ----
// types shared by the fetch front end
`default_nettype none
package fetch_pkg;
  typedef enum logic [1:0] {ph_t1, ph_t2, ph_t3, ph_t4} phase_t;
  typedef enum logic [2:0] {
    op_seq, op_jump, op_call, op_skip, op_intr, op_extended
  } op_kind_t;
  typedef enum logic [1:0] {sq_normal, sq_branch, sq_dummy} seq_t;
endpackage : fetch_pkg
`default_nettype wire

// ---- verilog/phase_gen.sv ----
// four non-overlapping instruction phases from the system clock
`include "fetch_cfg.svh"
`default_nettype none
module phase_gen
  import fetch_pkg::*;
(
  input  wire logic        hclk,     // system clock
  input  wire logic        hresetn,  // async reset, active low
  input  wire logic        run,      // advance phases
  output fetch_pkg::phase_t phase,   // current phase
  output logic [3:0]       instruction_phase_clocks // one-hot phases
);
  import fetch_pkg::*;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      phase <= ph_t1;
    else if (run)
      phase <= phase_t'(phase + 2'h1);
  genvar g;
  generate
    for (g = 0; g < `PHASE_COUNT; g = g + 1)
    begin : g_ph
      assign instruction_phase_clocks[g] = (phase == phase_t'(g));
    end
  endgenerate
endmodule : phase_gen
`default_nettype wire

// ---- verif/fetch_pc_pipeline_assertions.sv ----
// port assertions for the fetch front end
`default_nettype none
module fetch_pc_pipeline_assertions #(
  parameter int PC_W = 13
)(
  input wire logic            hclk,       // clock
  input wire logic            hresetn,    // reset
  input wire logic            hreadyout,  // ready
  input wire logic            hresp,      // response
  input wire logic [PC_W-1:0] pmem_addr,  // fetch address
  input wire logic            pmem_rd,    // fetch strobe
  input wire logic [15:0]     instr,      // instruction
  input wire logic            exec_valid, // live slot
  input wire logic [3:0]      instruction_phase_clocks, // phases
  input wire logic [7:0]      acc         // accumulator
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire [3:0] ph = instruction_phase_clocks;
  a_phase_onehot: assert property ($onehot0(ph))
    else $error("phase outputs not one-hot");
  a_phase_order: assert property (
    ph == 4'h1 |=> ph == 4'h2 ##1 ph == 4'h4 ##1 ph == 4'h8 ##1 ph == 4'h1)
    else $error("phase order broken");
  a_fetch_in_t1: assert property (pmem_rd == (ph == 4'h1))
    else $error("fetch strobe outside first phase");
  a_pc_moves_t1: assert property ($changed(pmem_addr) |-> ph == 4'h1)
    else $error("counter moved outside first phase");
  a_instr_holds: assert property ((ph[2] | ph[3]) |-> $stable(instr))
    else $error("instruction changed during execution");
  a_valid_holds: assert property (
    (ph[2] | ph[3]) |-> $stable(exec_valid))
    else $error("slot validity changed during execution");
  a_acc_late: assert property ($changed(acc) |-> (ph[2] | ph[3]))
    else $error("accumulator changed outside late phases");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("register port stalled or errored");
  c_fetch: cover property (pmem_rd);
  c_dummy: cover property ($fell(exec_valid));
  c_alu: cover property ($changed(acc));
endmodule : fetch_pc_pipeline_assertions
`default_nettype wire

// ---- verif/prog_mem_model.sv ----
// program memory model: each word is a fixed pattern of its address
`default_nettype none
module prog_mem_model (
  input  wire logic        hclk,      // clock
  input  wire logic [12:0] pmem_addr, // fetch address
  input  wire logic        pmem_rd,   // fetch strobe
  output logic [15:0]      pmem_data  // instruction word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last = 16'h0000;
  always @(posedge hclk)
    if (pmem_rd)
      last <= {3'h5, pmem_addr};
  // idle bus shows the inverse so a late sample cannot pass
  assign pmem_data = pmem_rd ? {3'h5, pmem_addr} : ~last;
endmodule : prog_mem_model
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the fetch front end
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp, pmem_rd, exec_valid;
  logic [12:0] pmem_addr, s, d;
  logic [12:0] a = 13'h0;
  logic [15:0] pmem_data, instr;
  logic [3:0]  ph;
  logic [7:0]  acc;
  int          failures = 0, checks = 0, dead = 0, dd, j, r;
  logic [7:0]  opnd [8] = '{8'h5A, 8'h0F, 8'h09, 8'h3C, 8'h81, 8'hFF,
                            8'h00, 8'h00};
  logic [7:0]  res [8] = '{8'h5A, 8'h69, 8'h60, 8'h20, 8'hA1, 8'h5E,
                           8'hBC, 8'hBD};
  logic [2:0]  knd [3] = '{3'h2, 3'h4, 3'h1};
  logic [12:0] tgt [3] = '{13'h0C33, 13'h0777, 13'h1A05};

  always #50 hclk = ~hclk;

  fetch_pc_pipeline u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_data(pmem_data), .instr(instr), .exec_valid(exec_valid),
    .instruction_phase_clocks(ph), .acc(acc)
  );
  prog_mem_model u_mem (
    .hclk(hclk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_data(pmem_data)
  );

  // fetch monitor: counts dead slots, repeats and non-unit steps
  always @(posedge hclk)
  begin
    if (ph === 4'h4 && exec_valid === 1'b0)
      dead++;
    if (pmem_rd === 1'b1)
    begin
      if (pmem_addr == a)
        r++;
      else if (pmem_addr != a + 13'h1)
      begin
        j++;
        s = a;
        d = pmem_addr;
      end
      a = pmem_addr;
    end
  end

  task chk(input logic [31:0] sv, input logic [31:0] ev);
    checks++;
    if (sv !== ev)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, sv, ev);
    end
  endtask : chk

  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task rd(input logic [7:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0);
    chk(q, e);
  endtask : rd

  task wait_fetch(input int n);
    repeat (n)
      do @(posedge hclk); while (pmem_rd !== 1'b1);
    @(negedge hclk);
  endtask : wait_fetch

  // clears the step and repeat counts and notes the dead count off the sampling edge, then watches 8 fetches
  task op(input logic [7:0] ad, input logic [31:0] v);
    @(negedge hclk);
    j = 0;
    r = 0;
    dd = dead;
    xfer(1'b1, ad, v);
    wait_fetch(8);
  endtask : op

  task results;
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial
  begin
    repeat (3000) @(posedge hclk);
    failures++;
    results;
  end

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    xfer(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    xfer(1'b1, 8'h04, 32'h1);
    wait_fetch(1);
    chk(a, 13'h0);
    chk(ph, 4'h2);
    wait_fetch(1);
    chk(instr, 16'hA000);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, 8'h18, {21'h0, i[2:0], opnd[i]});
      repeat (4) @(posedge hclk);
      rd(8'h18, {24'h0, res[i]});
    end
    op(8'h14, 32'h0);
    chk(j, 0);
    chk(r, 0);
    chk(dead - dd, 0);
    for (int i = 0; i < 3; i++)
    begin
      op(8'h14, {13'h0, knd[i], 3'h0, tgt[i]});
      chk(j, 1);
      chk(d, tgt[i]);
      chk(dead - dd, 2);
    end
    op(8'h00, 32'h40);
    chk(j, 1);
    chk(d, {s[12:8], 8'h40});
    chk(d[12:8], 5'h1A);
    chk(dead - dd, 2);
    op(8'h14, 32'h0003_0000);
    chk(j, 0);
    chk(r, 0);
    chk(dead - dd, 1);
    op(8'h14, 32'h0005_0000);
    chk(j, 0);
    chk(r, 1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h0C, 32'h0);
    xfer(1'b1, 8'h04, 32'h1);
    wait_fetch(1);
    chk(a, 13'h0);
    results;
  end
endmodule : testbench

bind fetch_pc_pipeline fetch_pc_pipeline_assertions #(.PC_W(PC_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .instr(instr),
  .exec_valid(exec_valid), .acc(acc),
  .instruction_phase_clocks(instruction_phase_clocks)
);
`default_nettype wire
